// ---- rtl/timer2_pkg.sv ----
// Behaviour
// (RL1) count is a 16-bit up-counter built from software low and high bytes
// (RL2) ext select clear: prescaled system clock counts; set: pin falling edges
// (RL3) mode from run, rx/tx clock bits and capture/reload bit
// (RL4) counting only while run is set; clearing run stops every mode
// (RL5) capture mode with trigger enable: trigger fall copies count into pair
// (RL6) trigger enable clear: trigger pin ignored, no capture, reload or flag
// (RL7) capture/reload modes: wrap FFFF to 0000 sets overflow flag, requests irq
// (RL8) reload mode: overflow loads the reload pair into the counter
// (RL9) reload mode with trigger enable: trigger fall also reloads counter
// (RL10) either uart clock bit set forces reload behaviour, ignores select bit
// (RL11) baud mode: no overflow flag; overflows go out as uart shift ticks
// (RL12) rx and tx clock bits independently pick timer 2 or timer 1 ticks
// (RL13) baud mode internal clocking uses system clock divided by two only
// (RL14) uart bit time equals sixteen selected overflow ticks
// (RL15) baud mode with ext select counts pin falling edges
// (RL16) baud mode trigger fall with enable sets external event flag
// (RL17) outside baud, trigger-caused capture or reload sets external event flag
// (RL18) hardware never clears either flag; software clears by writing
// (RL19) overflow event offered as trigger to converter start logic
// (RL20) reload/capture pair: captured value or reload value, rw, resets zero
// (RL21) prescale bypass 0 picks clock/12, 1 undivided; ignored baud/ext count
// (RL22) count and trigger pins synchronised, one pulse per falling edge
// (RL23) software counter byte write wins over increment or reload
package timer2_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register addresses
  localparam logic [7:0] ADDR_CONTROL = 8'hC8;
  localparam logic [7:0] ADDR_RCAP_LOW = 8'hCA;
  localparam logic [7:0] ADDR_RCAP_HIGH = 8'hCB;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'hCC;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'hCD;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and counts
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] RCAP_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_STEP = 16'h0001;
  localparam int PRESCALE_DIV = 12;
  localparam int BAUD_DIV = 2;
  localparam int BIT_TICKS = 16;

  ////////////////////////////////////////////////////////////////////////////
  // control register, msb first
  typedef struct packed {
    logic overflow_flag;
    logic ext_event_flag;
    logic rx_clock_source_sel;
    logic tx_clock_source_sel;
    logic ext_trigger_enable;
    logic run_control;
    logic ext_count_select;
    logic capture_reload_select;
  } control_s;

  typedef enum logic [3:0] {
    MODE_OFF = 4'h1,
    MODE_CAPTURE = 4'h2,
    MODE_RELOAD = 4'h4,
    MODE_BAUD = 4'h8
  } mode_e;

endpackage

// ---- rtl/pin_fall_detect.sv ----
`timescale 1ns/10ps
module pin_fall_detect (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // pin and event
  input wire logic i_pin,
  output logic o_fall
);
  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  // first stage feeds only the second
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      last_ff <= 1'b1;
    end else begin
      meta_ff <= i_pin;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign o_fall = last_ff & ~sync_ff; // RL22

endmodule // pin_fall_detect

// ---- rtl/timer2_capture_reload_baud.sv ----
`timescale 1ns/10ps
module timer2_capture_reload_baud (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // register port
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  // clock control bit and pins
  input wire logic i_prescale_bypass,
  input wire logic i_ext_count_pin,
  input wire logic i_ext_trigger_pin,
  // timer 1 overflow, same clock
  input wire logic i_timer1_ovf,
  // events out
  output logic o_timer2_irq,
  output logic o_rx_shift_tick,
  output logic o_tx_shift_tick,
  output logic o_rx_bit_tick,
  output logic o_tx_bit_tick,
  output logic o_adc_start_trigger
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  timer2_pkg::control_s ctrl_ff;
  timer2_pkg::control_s nxt_ctrl;
  timer2_pkg::mode_e mode;
  logic [15:0] count_ff;
  logic [15:0] nxt_count;
  logic [15:0] rcap_ff;
  logic [15:0] nxt_rcap;
  logic [3:0] div12_ff;
  logic div2_ff;
  logic [3:0] rx_bits_ff;
  logic [3:0] tx_bits_ff;
  logic ext_fall;
  logic trig_fall;
  logic baud;
  logic internal_tick;
  logic count_tick;
  logic ovf;
  logic trig;
  logic reload_now;
  logic rx_sel_tick;
  logic tx_sel_tick;
  logic ctrl_wr;
  logic lo_wr;
  logic hi_wr;
  logic rcap_lo_wr;
  logic rcap_hi_wr;

  assign ctrl_wr = i_sfr_wr && (i_sfr_addr == timer2_pkg::ADDR_CONTROL);
  assign lo_wr = i_sfr_wr && (i_sfr_addr == timer2_pkg::ADDR_COUNT_LOW);
  assign hi_wr = i_sfr_wr && (i_sfr_addr == timer2_pkg::ADDR_COUNT_HIGH);
  assign rcap_lo_wr = i_sfr_wr && (i_sfr_addr == timer2_pkg::ADDR_RCAP_LOW);
  assign rcap_hi_wr = i_sfr_wr && (i_sfr_addr == timer2_pkg::ADDR_RCAP_HIGH);

  ////////////////////////////////////////////////////////////////////////////
  // pins
  pin_fall_detect u_count_pin (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_pin(i_ext_count_pin),
    .o_fall(ext_fall)
  );

  pin_fall_detect u_trigger_pin (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_pin(i_ext_trigger_pin),
    .o_fall(trig_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // mode decode
  assign baud = ctrl_ff.rx_clock_source_sel | ctrl_ff.tx_clock_source_sel;

  always_comb begin
    if (!ctrl_ff.run_control) begin
      mode = timer2_pkg::MODE_OFF; // RL3 RL4
    end else if (baud) begin
      mode = timer2_pkg::MODE_BAUD; // RL10
    end else if (ctrl_ff.capture_reload_select) begin
      mode = timer2_pkg::MODE_CAPTURE; // RL3
    end else begin
      mode = timer2_pkg::MODE_RELOAD; // RL3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescalers, free running so the phase does not depend on mode
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      div12_ff <= 4'h0;
    end else if (div12_ff == 4'(timer2_pkg::PRESCALE_DIV - 1)) begin
      div12_ff <= 4'h0;
    end else begin
      div12_ff <= div12_ff + 4'h1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      div2_ff <= 1'b0;
    end else begin
      div2_ff <= ~div2_ff;
    end
  end

  always_comb begin
    if (baud) begin
      internal_tick = div2_ff; // RL13
    end else if (i_prescale_bypass) begin
      internal_tick = 1'b1; // RL21
    end else begin
      internal_tick =
        (div12_ff == 4'(timer2_pkg::PRESCALE_DIV - 1)); // RL21
    end
  end

  // RL2 RL15
  assign count_tick = (mode != timer2_pkg::MODE_OFF) &&
                      (ctrl_ff.ext_count_select ? ext_fall : internal_tick);
  assign ovf = count_tick && (count_ff == timer2_pkg::COUNT_MAX);
  // trigger only when enabled and running
  assign trig = trig_fall && ctrl_ff.ext_trigger_enable &&
                (mode != timer2_pkg::MODE_OFF); // RL6
  assign reload_now = (ovf && mode != timer2_pkg::MODE_CAPTURE) ||
                      (trig && mode == timer2_pkg::MODE_RELOAD); // RL8 RL9

  ////////////////////////////////////////////////////////////////////////////
  // counter
  always_comb begin
    nxt_count = count_ff;
    if (reload_now) begin
      nxt_count = rcap_ff; // RL8 RL10
    end else if (count_tick) begin
      nxt_count = count_ff + timer2_pkg::COUNT_STEP; // RL1
    end
    if (lo_wr) begin
      nxt_count[7:0] = i_sfr_wdata; // RL23
    end
    if (hi_wr) begin
      nxt_count[15:8] = i_sfr_wdata; // RL23
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      count_ff <= timer2_pkg::COUNT_RESET;
    end else begin
      count_ff <= nxt_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reload/capture pair; a capture beats a same-cycle write
  always_comb begin
    nxt_rcap = rcap_ff;
    if (rcap_lo_wr) begin
      nxt_rcap[7:0] = i_sfr_wdata; // RL20
    end
    if (rcap_hi_wr) begin
      nxt_rcap[15:8] = i_sfr_wdata; // RL20
    end
    if (trig && mode == timer2_pkg::MODE_CAPTURE) begin
      nxt_rcap = count_ff; // RL5
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rcap_ff <= timer2_pkg::RCAP_RESET;
    end else begin
      rcap_ff <= nxt_rcap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control and flags; hardware set wins over a software clear
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (ctrl_wr) begin
      nxt_ctrl = timer2_pkg::control_s'(i_sfr_wdata); // RL18
    end
    if (ovf && !baud) begin
      nxt_ctrl.overflow_flag = 1'b1; // RL7 RL11
    end
    if (trig) begin
      nxt_ctrl.ext_event_flag = 1'b1; // RL16 RL17
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ctrl_ff <= timer2_pkg::control_s'(timer2_pkg::CONTROL_RESET);
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_timer2_irq <= 1'b0;
    end else begin
      o_timer2_irq <= nxt_ctrl.overflow_flag | nxt_ctrl.ext_event_flag; // RL7
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // uart and converter ticks
  assign rx_sel_tick = ctrl_ff.rx_clock_source_sel ?
                       (ovf && baud) : i_timer1_ovf; // RL12
  assign tx_sel_tick = ctrl_ff.tx_clock_source_sel ?
                       (ovf && baud) : i_timer1_ovf; // RL12

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_rx_shift_tick <= 1'b0;
      o_tx_shift_tick <= 1'b0;
      o_adc_start_trigger <= 1'b0;
    end else begin
      o_rx_shift_tick <= rx_sel_tick; // RL11
      o_tx_shift_tick <= tx_sel_tick; // RL11
      o_adc_start_trigger <= ovf; // RL19
    end
  end

  // sixteen ticks per bit; divider is per direction so rx and tx may differ
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rx_bits_ff <= 4'h0;
      tx_bits_ff <= 4'h0;
      o_rx_bit_tick <= 1'b0;
      o_tx_bit_tick <= 1'b0;
    end else begin
      rx_bits_ff <= rx_bits_ff + {3'h0, rx_sel_tick};
      tx_bits_ff <= tx_bits_ff + {3'h0, tx_sel_tick};
      o_rx_bit_tick <= rx_sel_tick &&
        (rx_bits_ff == 4'(timer2_pkg::BIT_TICKS - 1)); // RL14
      o_tx_bit_tick <= tx_sel_tick &&
        (tx_bits_ff == 4'(timer2_pkg::BIT_TICKS - 1)); // RL14
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_sfr_rdata <= 8'h00;
    end else if (i_sfr_rd) begin
      unique case (i_sfr_addr)
        timer2_pkg::ADDR_CONTROL: o_sfr_rdata <= ctrl_ff;
        timer2_pkg::ADDR_RCAP_LOW: o_sfr_rdata <= rcap_ff[7:0];
        timer2_pkg::ADDR_RCAP_HIGH: o_sfr_rdata <= rcap_ff[15:8];
        timer2_pkg::ADDR_COUNT_LOW: o_sfr_rdata <= count_ff[7:0];
        timer2_pkg::ADDR_COUNT_HIGH: o_sfr_rdata <= count_ff[15:8];
        default: o_sfr_rdata <= 8'h00;
      endcase
    end else begin
      o_sfr_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_wrap;
    count_tick && (count_ff == timer2_pkg::COUNT_MAX);
  endsequence

  sequence s_quiet_bus;
    !i_sfr_wr;
  endsequence

  chk_ovf_flag_set: assert property ( // RL7
    @(posedge i_ref_clk) disable iff (i_rst)
    (s_wrap and (!baud)) |=> ctrl_ff.overflow_flag)
    else $error("overflow did not set flag");

  chk_baud_no_flag: assert property ( // RL11
    @(posedge i_ref_clk) disable iff (i_rst)
    (s_wrap and (baud && !ctrl_ff.overflow_flag) and s_quiet_bus)
      |=> !ctrl_ff.overflow_flag)
    else $error("baud overflow set flag");

  chk_reload_value: assert property ( // RL8
    @(posedge i_ref_clk) disable iff (i_rst)
    (s_wrap and (mode != timer2_pkg::MODE_CAPTURE) and s_quiet_bus)
      |=> count_ff == $past(rcap_ff))
    else $error("reload value wrong");

  chk_capture_copy: assert property ( // RL5
    @(posedge i_ref_clk) disable iff (i_rst)
    (trig && mode == timer2_pkg::MODE_CAPTURE) |=> rcap_ff == $past(count_ff))
    else $error("capture missed");

  chk_trigger_ignored: assert property ( // RL6
    @(posedge i_ref_clk) disable iff (i_rst)
    (!ctrl_ff.ext_trigger_enable && !ctrl_ff.ext_event_flag && !i_sfr_wr)
      |=> !ctrl_ff.ext_event_flag && $stable(rcap_ff))
    else $error("trigger not ignored");

  chk_stop_hold: assert property ( // RL4
    @(posedge i_ref_clk) disable iff (i_rst)
    (!ctrl_ff.run_control && !i_sfr_wr) [*2] |=> $stable(count_ff))
    else $error("counter moved while stopped");

  chk_flag_sticky: assert property ( // RL18
    @(posedge i_ref_clk) disable iff (i_rst)
    ((ctrl_ff.overflow_flag && !ctrl_wr) |=> ctrl_ff.overflow_flag) and
    ((ctrl_ff.ext_event_flag && !ctrl_wr) |=> ctrl_ff.ext_event_flag))
    else $error("flag cleared by hardware");

  chk_adc_trigger: assert property ( // RL19
    @(posedge i_ref_clk) disable iff (i_rst)
    s_wrap |=> o_adc_start_trigger ##1 (!o_adc_start_trigger || $past(ovf)))
    else $error("converter trigger missing");

  chk_write_priority: assert property ( // RL23
    @(posedge i_ref_clk) disable iff (i_rst)
    lo_wr |=> count_ff[7:0] == $past(i_sfr_wdata))
    else $error("byte write lost");

  chk_baud_half_rate: assert property ( // RL13
    @(posedge i_ref_clk) disable iff (i_rst)
    (baud && !ctrl_ff.ext_count_select && count_tick) |=> !count_tick)
    else $error("baud count faster than half clock");

  chk_event_flag_set: assert property ( // RL16
    @(posedge i_ref_clk) disable iff (i_rst)
    trig |=> ctrl_ff.ext_event_flag)
    else $error("trigger did not set event flag");

endmodule // timer2_capture_reload_baud

// ---- dv/uart_adc_event_sink.sv ----
`timescale 1ns/10ps
module uart_adc_event_sink (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // ticks from the timer
  input wire logic i_rx_shift,
  input wire logic i_tx_shift,
  input wire logic i_rx_bit,
  input wire logic i_tx_bit,
  input wire logic i_adc_start,
  // running totals
  output logic [15:0] o_rx_shift_cnt,
  output logic [15:0] o_tx_shift_cnt,
  output logic [15:0] o_rx_bit_cnt,
  output logic [15:0] o_tx_bit_cnt,
  output logic [15:0] o_adc_cnt
);
  ////////////////////////////////////////////////////////////////////////////
  // every tick is one cycle wide, so one count per high cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_rx_shift_cnt <= 16'h0000;
      o_tx_shift_cnt <= 16'h0000;
    end else begin
      o_rx_shift_cnt <= o_rx_shift_cnt + {15'h0000, i_rx_shift};
      o_tx_shift_cnt <= o_tx_shift_cnt + {15'h0000, i_tx_shift};
    end
  end

  // bit clock and converter start taken as the uart and adc would
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_rx_bit_cnt <= 16'h0000;
      o_tx_bit_cnt <= 16'h0000;
      o_adc_cnt <= 16'h0000;
    end else begin
      o_rx_bit_cnt <= o_rx_bit_cnt + {15'h0000, i_rx_bit};
      o_tx_bit_cnt <= o_tx_bit_cnt + {15'h0000, i_tx_bit};
      o_adc_cnt <= o_adc_cnt + {15'h0000, i_adc_start};
    end
  end
endmodule // uart_adc_event_sink

// ---- dv/testbench.sv ----
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic bypass = 1'b0;
  logic cpin = 1'b1;
  logic tpin = 1'b1;
  logic t1ovf = 1'b0;
  logic irq, rxs, txs, rxb, txb, adc;
  logic [15:0] rxs_n, txs_n, rxb_n, txb_n, adc_n;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;

  timer2_capture_reload_baud dut (
    .i_ref_clk(clk), .i_rst(rst), .i_sfr_addr(addr), .i_sfr_wr(wr),
    .i_sfr_rd(rd), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata),
    .i_prescale_bypass(bypass), .i_ext_count_pin(cpin),
    .i_ext_trigger_pin(tpin), .i_timer1_ovf(t1ovf), .o_timer2_irq(irq),
    .o_rx_shift_tick(rxs), .o_tx_shift_tick(txs), .o_rx_bit_tick(rxb),
    .o_tx_bit_tick(txb), .o_adc_start_trigger(adc)
  );

  uart_adc_event_sink sink (
    .i_ref_clk(clk), .i_rst(rst), .i_rx_shift(rxs), .i_tx_shift(txs),
    .i_rx_bit(rxb), .i_tx_bit(txb), .i_adc_start(adc),
    .o_rx_shift_cnt(rxs_n), .o_tx_shift_cnt(txs_n), .o_rx_bit_cnt(rxb_n),
    .o_tx_bit_cnt(txb_n), .o_adc_cnt(adc_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #25 clk = ~clk;
  end

  // generous ceiling, the sequence needs well under two thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (n_fail == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic rng(input logic [15:0] got, lo, hi);
    total_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      n_fail++;
      $display("BAD t=%0t got=%h want=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic chk(input logic [15:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h want=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, d);
    tick(1);
    addr = a;
    wdata = d;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    tick(1);
    addr = a;
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    d = rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, exp);
    logic [7:0] d;
    rd_reg(a, d);
    chk({8'h00, d}, {8'h00, exp});
  endtask

  // pin pulses stay low and high for several clocks, above the minimum
  task automatic trig_fall();
    tpin = 1'b0;
    tick(3);
    tpin = 1'b1;
    tick(6);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd_chk(8'hC8, 8'h00);
    rd_chk(8'hCA, 8'h00);
    rd_chk(8'hCB, 8'h00);
    rd_chk(8'hCC, 8'h00);
    rd_chk(8'hCD, 8'h00);
    wr_reg(8'hCA, 8'hA5);
    wr_reg(8'hCB, 8'h5A);
    wr_reg(8'hCC, 8'h3C);
    wr_reg(8'hCD, 8'hC3);
    wr_reg(8'hC9, 8'hFF);
    rd_chk(8'hCA, 8'hA5);
    rd_chk(8'hCB, 8'h5A);
    rd_chk(8'hCC, 8'h3C);
    rd_chk(8'hCD, 8'hC3);
    rd_chk(8'hC9, 8'h00);
  endtask

  task automatic t_reload_ovf();
    logic [7:0] d, e;
    logic [15:0] a0;
    bypass = 1'b1;
    wr_reg(8'hCA, 8'hF0);
    wr_reg(8'hCB, 8'hFF);
    wr_reg(8'hCC, 8'hFA);
    wr_reg(8'hCD, 8'hFF);
    a0 = adc_n;
    wr_reg(8'hC8, 8'h04);
    tick(10);
    wr_reg(8'hC8, 8'h80);
    rd_chk(8'hC8, 8'h80);
    chk({15'h0000, irq}, 16'h0001);
    rd_chk(8'hCD, 8'hFF);
    rd_reg(8'hCC, d);
    rng({8'h00, d}, 16'h00F0, 16'h00FF);
    chk(adc_n - a0, 16'h0001);
    tick(20);
    rd_reg(8'hCC, e);
    chk({8'h00, e}, {8'h00, d});
    rd_chk(8'hC8, 8'h80);
    wr_reg(8'hC8, 8'h00);
  endtask

  task automatic t_prescale();
    logic [7:0] d;
    bypass = 1'b0;
    wr_reg(8'hCC, 8'h00);
    wr_reg(8'hCD, 8'h00);
    wr_reg(8'hC8, 8'h04);
    tick(120);
    wr_reg(8'hC8, 8'h00);
    rd_reg(8'hCC, d);
    rng({8'h00, d}, 16'h0009, 16'h000B);
  endtask

  task automatic t_ext_count();
    bypass = 1'b1;
    wr_reg(8'hCC, 8'h00);
    wr_reg(8'hC8, 8'h06);
    repeat (5) begin
      cpin = 1'b0;
      tick(3);
      cpin = 1'b1;
      tick(3);
    end
    tick(6);
    wr_reg(8'hC8, 8'h00);
    rd_chk(8'hCC, 8'h05);
  endtask

  task automatic t_capture();
    logic [7:0] c;
    bypass = 1'b0;
    wr_reg(8'hCC, 8'h34);
    wr_reg(8'hCD, 8'h12);
    wr_reg(8'hC8, 8'h0D);
    trig_fall();
    rd_chk(8'hCB, 8'h12);
    rd_reg(8'hCA, c);
    rng({8'h00, c}, 16'h0034, 16'h0035);
    rd_chk(8'hC8, 8'h4D);
    chk({15'h0000, irq}, 16'h0001);
    tick(20);
    rd_chk(8'hC8, 8'h4D);
    wr_reg(8'hC8, 8'h05);
    trig_fall();
    rd_chk(8'hCA, c);
    rd_chk(8'hC8, 8'h05);
    chk({15'h0000, irq}, 16'h0000);
  endtask

  task automatic t_trig_reload();
    wr_reg(8'hCA, 8'hCD);
    wr_reg(8'hCB, 8'hAB);
    wr_reg(8'hCC, 8'h10);
    wr_reg(8'hCD, 8'h00);
    wr_reg(8'hC8, 8'h0C);
    trig_fall();
    rd_chk(8'hC8, 8'h4C);
    wr_reg(8'hC8, 8'h48);
    rd_chk(8'hCD, 8'hAB);
    rd_chk(8'hC8, 8'h48);
  endtask

  task automatic t_baud();
    logic [15:0] r0, t0, rb0, tb0;
    bypass = 1'b0;
    wr_reg(8'hCA, 8'hFE);
    wr_reg(8'hCB, 8'hFF);
    wr_reg(8'hCC, 8'hFE);
    wr_reg(8'hCD, 8'hFF);
    wr_reg(8'hC8, 8'h35);
    r0 = rxs_n;
    t0 = txs_n;
    rb0 = rxb_n;
    tb0 = txb_n;
    tick(160);
    // divide by two and two counts per wrap: one shift tick per 4 cycles
    rng(rxs_n - r0, 16'd39, 16'd41);
    rng(txs_n - t0, 16'd39, 16'd41);
    rng(rxb_n - rb0, 16'd2, 16'd3);
    rng(txb_n - tb0, 16'd2, 16'd3);
    rd_chk(8'hC8, 8'h35);
    wr_reg(8'hC8, 8'h24);
    // a tick launched by the old mode is still in flight
    tick(2);
    r0 = rxs_n;
    t0 = txs_n;
    repeat (7) begin
      t1ovf = 1'b1;
      tick(1);
      t1ovf = 1'b0;
      tick(3);
    end
    tick(2);
    chk(txs_n - t0, 16'd7);
    rng(rxs_n - r0, 16'd6, 16'd9);
    wr_reg(8'hC8, 8'h3C);
    trig_fall();
    rd_chk(8'hC8, 8'h7C);
    chk({15'h0000, irq}, 16'h0001);
    // pin-clocked baud: reload FFFE wraps once per two falls
    wr_reg(8'hC8, 8'h36);
    tick(2);
    t0 = txs_n;
    repeat (4) begin
      cpin = 1'b0;
      tick(3);
      cpin = 1'b1;
      tick(3);
    end
    tick(6);
    chk(txs_n - t0, 16'd2);
    wr_reg(8'hC8, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    t_regs();
    t_reload_ovf();
    t_prescale();
    t_ext_count();
    t_capture();
    t_trig_reload();
    t_baud();
    print_verdict();
  end
endmodule // testbench
